// ==== rtl/coh_pkg.sv ====
// Purpose: Shared constants for the comparator output handshake block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Result vectors are ordered {above, pass, under}
`default_nettype none
package coh_pkg;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] INT_STATUS_OFS = 8'h08;
	localparam logic [7:0] INT_ENABLE_OFS = 8'h0c;
	localparam logic [7:0] INT_CLEAR_OFS = 8'h10;

	localparam int CTRL_W = 4;
	localparam int CTRL_COMP_EN_BIT = 0;
	localparam int CTRL_MANUAL_BIT = 1;
	localparam int CTRL_RV_BIT = 2;
	localparam int CTRL_HOLD_BIT = 3;
	localparam logic [3:0] CTRL_RST = 4'h3;

	localparam int RES_W = 3;
	localparam int RES_ABOVE_BIT = 2;
	localparam int RES_PASS_BIT = 1;
	localparam int RES_UNDER_BIT = 0;
	localparam logic [2:0] RES_NONE = 3'h0;
	localparam logic [2:0] RES_RV_FAIL = 3'h6;

	localparam int ST_FAULT_BIT = 3;
	localparam int ST_EOC_BIT = 4;
	localparam int ST_VALID_BIT = 5;
	localparam int ST_SERVED_BIT = 6;

	localparam int INT_W = 3;
	localparam int INT_EOC_BIT = 0;
	localparam int INT_FAULT_BIT = 1;
	localparam int INT_REQ_BIT = 2;
	localparam logic [2:0] INT_RST = 3'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		COH_IDLE = 2'b01,
		COH_BUSY = 2'b10
	} coh_meas_state_t;
endpackage
`default_nettype wire

// ==== rtl/coh_sync_edge.sv ====
// Purpose: Two-flop synchroniser with rising-edge pulse
// Assumes: Input pulses are longer than two clock periods
// Notes: First flop feeds only the second flop
`timescale 1ns/1ps
`default_nettype none
module coh_sync_edge (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	logic meta_reg;
	logic meta_next;
	logic stable_reg;
	logic stable_next;
	logic prev_reg;
	logic prev_next;

	always_comb begin
		meta_next = async_i;
		stable_next = meta_reg;
		prev_next = stable_reg;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta_reg <= 1'b0;
			stable_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			stable_reg <= stable_next;
			prev_reg <= prev_next;
		end
	end

	// One event per asserted pulse, however long it stands
	assign rise_o = stable_reg & ~prev_reg;
	assign level_o = stable_reg;
endmodule
`default_nettype wire

// ==== rtl/coh_top.sv ====
// Purpose: Comparator output handshake with fault flag, end-of-measure and AHB-Lite registers
// Assumes: Measurement engine reports begin/done pulses and a one-hot result {above,pass,under}
// Notes: Zero-wait AHB-Lite slave; read data registered in the address phase
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module coh_top (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic compare_out_request_i,
	input wire logic measure_fire_i,
	input wire logic print_request_i,
	input wire logic contact_ok_i,
	input wire logic analog_fault_i,
	input wire logic meas_begin_i,
	input wire logic meas_done_i,
	input wire logic [2:0] meas_result_i,
	output logic meas_start_o,
	output logic print_go_o,
	output logic above_limit_o,
	output logic pass_o,
	output logic under_limit_o,
	output logic meas_end_o,
	output logic fault_flag_o,
	output logic irq_o
);
	logic req_rise;
	logic fire_rise;
	logic print_rise;

	coh_sync_edge u_req_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.async_i(compare_out_request_i),
		.level_o(),
		.rise_o(req_rise)
	);
	coh_sync_edge u_fire_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.async_i(measure_fire_i),
		.level_o(),
		.rise_o(fire_rise)
	);
	coh_sync_edge u_print_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.async_i(print_request_i),
		.level_o(),
		.rise_o(print_rise)
	);

	function automatic logic [2:0] map_res(input logic [2:0] res, input logic rv);
		// Voltage-and-resistance fail lights above and pass together
		if (rv && (res[coh_pkg::RES_ABOVE_BIT] || res[coh_pkg::RES_UNDER_BIT]))
			return coh_pkg::RES_RV_FAIL;
		return res;
	endfunction

	// Bus and register group
	logic [3:0] ctrl_reg, ctrl_next;
	logic [2:0] int_en_reg, int_en_next;
	logic [2:0] int_stat_reg, int_stat_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] waddr_reg, waddr_next;
	logic wr_pend_reg, wr_pend_next;
	logic [2:0] events;
	logic [31:0] status_word;

	// Measurement and output group
	coh_pkg::coh_meas_state_t state_reg, state_next;
	logic [2:0] last_res_reg, last_res_next;
	logic [2:0] shown_reg, shown_next;
	logic [2:0] out_reg, out_next;
	logic valid_reg, valid_next;
	logic served_reg, served_next;
	logic fault_reg, fault_next;
	logic eoc_reg, eoc_next;
	logic start_reg, start_next;
	logic print_reg, print_next;

	logic comp_en, manual, rv, hold;
	logic fault_now;
	logic addr_phase, req_ok, start_now;
	logic [2:0] res_now;
	logic valid_now;

	assign comp_en = ctrl_reg[coh_pkg::CTRL_COMP_EN_BIT];
	assign manual = ctrl_reg[coh_pkg::CTRL_MANUAL_BIT];
	assign rv = ctrl_reg[coh_pkg::CTRL_RV_BIT];
	assign hold = ctrl_reg[coh_pkg::CTRL_HOLD_BIT];
	assign addr_phase = hsel_i && hready_i && (htrans_i == coh_pkg::HTRANS_NONSEQ || htrans_i == 2'h3);

	always_comb begin
		status_word = 32'h0;
		status_word[2:0] = last_res_reg;
		status_word[coh_pkg::ST_FAULT_BIT] = fault_reg;
		status_word[coh_pkg::ST_EOC_BIT] = eoc_reg;
		status_word[coh_pkg::ST_VALID_BIT] = valid_reg;
		status_word[coh_pkg::ST_SERVED_BIT] = served_reg;
	end

	always_comb begin
		events = 3'h0;
		events[coh_pkg::INT_EOC_BIT] = meas_done_i;
		events[coh_pkg::INT_FAULT_BIT] = fault_now && !fault_reg;
		events[coh_pkg::INT_REQ_BIT] = req_ok;
		ctrl_next = ctrl_reg;
		int_en_next = int_en_reg;
		int_stat_next = int_stat_reg;
		rdata_next = 32'h0;
		waddr_next = waddr_reg;
		wr_pend_next = 1'b0;
		if (wr_pend_reg) begin
			case (waddr_reg)
				coh_pkg::CTRL_OFS: ctrl_next = hwdata_i[3:0];
				coh_pkg::INT_ENABLE_OFS: int_en_next = hwdata_i[2:0];
				coh_pkg::INT_CLEAR_OFS: int_stat_next = int_stat_reg & ~hwdata_i[2:0];
				default: ctrl_next = ctrl_reg;
			endcase
		end
		// Set wins over a clear landing in the same cycle
		int_stat_next = int_stat_next | events;
		if (addr_phase) begin
			waddr_next = (haddr_i[31:8] == 24'h0) ? haddr_i[7:0] : 8'hff;
			wr_pend_next = hwrite_i && (hsize_i == coh_pkg::HSIZE_WORD);
			if (!hwrite_i && haddr_i[31:8] == 24'h0) begin
				case (haddr_i[7:0])
					coh_pkg::CTRL_OFS: rdata_next = {28'h0, ctrl_reg};
					coh_pkg::STATUS_OFS: rdata_next = status_word;
					coh_pkg::INT_STATUS_OFS: rdata_next = {29'h0, int_stat_reg};
					coh_pkg::INT_ENABLE_OFS: rdata_next = {29'h0, int_en_reg};
					default: rdata_next = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= coh_pkg::CTRL_RST;
			int_en_reg <= coh_pkg::INT_RST;
			int_stat_reg <= coh_pkg::INT_RST;
			rdata_reg <= 32'h0;
			waddr_reg <= 8'h0;
			wr_pend_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			int_en_reg <= int_en_next;
			int_stat_reg <= int_stat_next;
			rdata_reg <= rdata_next;
			waddr_reg <= waddr_next;
			wr_pend_reg <= wr_pend_next;
		end
	end

	// Trigger only counts in hold mode; free run ignores it
	assign start_now = fire_rise && hold;
	// Requests are ignored unless the comparator waits for them
	assign fault_now = !contact_ok_i || analog_fault_i;
	assign req_ok = req_rise && comp_en && manual && !fault_now;
	// A result finishing this very cycle counts as completed
	assign res_now = meas_done_i ? meas_result_i : last_res_reg;
	assign valid_now = meas_done_i || valid_reg;

	always_comb begin
		state_next = state_reg;
		eoc_next = eoc_reg;
		case (state_reg)
			coh_pkg::COH_IDLE: begin
				if (start_now || meas_begin_i) begin
					state_next = coh_pkg::COH_BUSY;
					eoc_next = 1'b0;
				end
			end
			coh_pkg::COH_BUSY: begin
				if (meas_done_i)
					state_next = coh_pkg::COH_IDLE;
			end
			default: state_next = coh_pkg::COH_IDLE;
		endcase
		// End-of-measure rises on the edge that loads the new result into last_res_reg
		if (meas_done_i)
			eoc_next = 1'b1;
		last_res_next = res_now;
		valid_next = valid_now;
		// Fault covers lost contact and internal faults, hold or not
		fault_next = fault_now;
		shown_next = shown_reg;
		served_next = served_reg && manual && !fault_next;
		if (req_ok) begin
			shown_next = map_res(res_now, rv);
			served_next = 1'b1;
		end
		if (fault_next || !comp_en)
			out_next = coh_pkg::RES_NONE;
		else if (manual)
			out_next = served_next ? shown_next : coh_pkg::RES_NONE;
		else
			out_next = valid_now ? map_res(res_now, rv) : coh_pkg::RES_NONE;
		start_next = start_now;
		// Printing does not wait for a measurement in flight
		print_next = print_rise;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_reg <= coh_pkg::COH_IDLE;
			last_res_reg <= coh_pkg::RES_NONE;
			shown_reg <= coh_pkg::RES_NONE;
			out_reg <= coh_pkg::RES_NONE;
			valid_reg <= 1'b0;
			served_reg <= 1'b0;
			fault_reg <= 1'b0;
			eoc_reg <= 1'b0;
			start_reg <= 1'b0;
			print_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			last_res_reg <= last_res_next;
			shown_reg <= shown_next;
			out_reg <= out_next;
			valid_reg <= valid_next;
			served_reg <= served_next;
			fault_reg <= fault_next;
			eoc_reg <= eoc_next;
			start_reg <= start_next;
			print_reg <= print_next;
		end
	end

	assign hrdata_o = rdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign above_limit_o = out_reg[coh_pkg::RES_ABOVE_BIT];
	assign pass_o = out_reg[coh_pkg::RES_PASS_BIT];
	assign under_limit_o = out_reg[coh_pkg::RES_UNDER_BIT];
	assign meas_end_o = eoc_reg;
	assign fault_flag_o = fault_reg;
	assign meas_start_o = start_reg;
	assign print_go_o = print_reg;
	assign irq_o = |(int_stat_reg & int_en_reg);

	sequence contact_good_s;
		contact_ok_i && !analog_fault_i;
	endsequence
	sequence done_in_busy_s;
		!meas_end_o ##0 meas_done_i;
	endsequence

	fault_release_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		contact_good_s |=> !fault_flag_o)
		else $error("fault flag not released with good contact");
	fault_raise_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!contact_ok_i |=> fault_flag_o)
		else $error("fault flag not raised on lost contact");
	fault_in_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(analog_fault_i && hold) |=> fault_flag_o)
		else $error("abnormal measurement missed in hold mode");
	req_latest_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(req_rise && comp_en && manual && !meas_done_i && contact_ok_i && !analog_fault_i)
		|=> {above_limit_o, pass_o, under_limit_o} == $past(map_res(last_res_reg, rv)))
		else $error("request did not show latest completed result");
	manual_quiet_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(manual && !served_reg && !req_rise && !$past(req_rise, 1))
		|-> {above_limit_o, pass_o, under_limit_o} == coh_pkg::RES_NONE)
		else $error("results shown before any request");
	fault_mask_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		fault_flag_o |-> !above_limit_o && !pass_o && !under_limit_o)
		else $error("result output during fault");
	eoc_rise_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		done_in_busy_s |=> meas_end_o && $rose(meas_end_o))
		else $error("end-of-measure did not rise after completion");
	eoc_fall_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(meas_start_o && !meas_done_i) |-> !meas_end_o)
		else $error("end-of-measure high during started measurement");
	rv_fail_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(comp_en && !manual && rv && meas_done_i && contact_ok_i && !analog_fault_i
		&& (meas_result_i[coh_pkg::RES_ABOVE_BIT] || meas_result_i[coh_pkg::RES_UNDER_BIT]))
		|=> above_limit_o && pass_o && !under_limit_o)
		else $error("voltage-resistance fail not shown as above plus pass");
	req_single_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		req_rise |-> ($past(compare_out_request_i, 2) && !$past(compare_out_request_i, 3)) ##1 !req_rise)
		else $error("one request pulse gave two events");
	print_now_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		print_rise |=> print_go_o ##1 !print_go_o)
		else $error("print pulse delayed or stretched");
endmodule
`default_nettype wire

// ==== tb/coh_line_ctrl.sv ====
// Purpose: Line controller model driving the request, trigger and print pins
// Assumes: Pins are sampled on the rising edge of clk_sys_i
// Notes: Every pulse is 3 cycles high then 3 low, well above the 2-cycle minimum
`timescale 1ns/1ps
`default_nettype none
module coh_line_ctrl (
	input wire logic clk_sys_i,
	input wire logic meas_end_i,
	output logic compare_out_request_o,
	output logic measure_fire_o,
	output logic print_request_o
);
	initial begin
		compare_out_request_o = 1'b0;
		measure_fire_o = 1'b0;
		print_request_o = 1'b0;
	end
	// Caller settles first; widths stay long, never tuned down
	task automatic pulse(input int pin);
		@(posedge clk_sys_i);
		case (pin)
			0: compare_out_request_o <= 1'b1;
			1: measure_fire_o <= 1'b1;
			default: print_request_o <= 1'b1;
		endcase
		repeat (3) @(posedge clk_sys_i);
		compare_out_request_o <= 1'b0;
		measure_fire_o <= 1'b0;
		print_request_o <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	// Results are taken only after end-of-measure is high
	task automatic await_end(output bit ok);
		ok = 1'b0;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge clk_sys_i);
			ok = (meas_end_i === 1'b1);
		end
	endtask
	task automatic print_after_end(output bit ok);
		await_end(ok);
		if (ok) begin
			pulse(2);
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the comparator output handshake
// Assumes: Zero-wait slave, hready looped back from hreadyout
// Notes: Expected values come from package constants and literal values
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst, hsel, hwrite, hready, hresp, contact, afault, mbegin, mdone;
	logic req, fire, prt, mstart, pgo, above, pass, under, mend, fault, irq;
	logic [1:0] htrans;
	logic [2:0] hsize, mres, res;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int bad_count = 0;
	int comparisons = 0;
	int starts = 0;
	int prints = 0;
	int n;
	bit ok;
	assign res = {above, pass, under};
	coh_top coh_top_inst (.clk_sys_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .compare_out_request_i(req),
		.measure_fire_i(fire), .print_request_i(prt), .contact_ok_i(contact), .analog_fault_i(afault),
		.meas_begin_i(mbegin), .meas_done_i(mdone), .meas_result_i(mres), .meas_start_o(mstart),
		.print_go_o(pgo), .above_limit_o(above), .pass_o(pass), .under_limit_o(under),
		.meas_end_o(mend), .fault_flag_o(fault), .irq_o(irq));
	coh_line_ctrl coh_line_ctrl_inst (.clk_sys_i(clk), .meas_end_i(mend), .compare_out_request_o(req),
		.measure_fire_o(fire), .print_request_o(prt));
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic stop_hang;
		bad_count++;
		give_verdict();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic chkr(input logic [2:0] e);
		chk("results", {29'h0, e}, {29'h0, res});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic hold_wait;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			stop_hang();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		htrans <= coh_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		hold_wait();
		htrans <= 2'h0;
		hwdata <= wd;
		hold_wait();
		rd = hrdata;
	endtask
	task automatic done_pulse(input logic [2:0] r);
		@(posedge clk);
		mdone <= 1'b1;
		mres <= r;
		@(posedge clk);
		mdone <= 1'b0;
		cyc(2);
	endtask
	task automatic set_contact(input logic v);
		@(posedge clk);
		contact <= v;
		cyc(3);
	endtask
	task automatic t_reset;
		chkr(3'h0);
		chkb("fault", 1'b0, fault);
		chkb("hresp", 1'b0, hresp);
		bus(1'b0, coh_pkg::CTRL_OFS, 32'h0);
		chk("ctrl", {28'h0, coh_pkg::CTRL_RST}, rd);
		bus(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
	endtask
	task automatic t_fault;
		set_contact(1'b0);
		chkb("fault", 1'b1, fault);
		set_contact(1'b1);
		chkb("fault", 1'b0, fault);
		@(posedge clk);
		afault <= 1'b1;
		cyc(3);
		chkb("fault", 1'b1, fault);
		@(posedge clk);
		afault <= 1'b0;
		cyc(3);
		$display("test fault done");
	endtask
	task automatic t_request;
		done_pulse(3'h2);
		chkr(3'h0);
		@(posedge clk);
		mbegin <= 1'b1;
		@(posedge clk);
		mbegin <= 1'b0;
		coh_line_ctrl_inst.pulse(0);
		chkr(3'h2);
		done_pulse(3'h4);
		chkr(3'h2);
		coh_line_ctrl_inst.pulse(0);
		chkr(3'h4);
		set_contact(1'b0);
		chkr(3'h0);
		set_contact(1'b1);
		chkr(3'h0);
		bus(1'b1, coh_pkg::CTRL_OFS, 32'h7);
		done_pulse(3'h1);
		coh_line_ctrl_inst.pulse(0);
		chkr(coh_pkg::RES_RV_FAIL);
		$display("test request done");
	endtask
	task automatic t_trigger;
		bus(1'b1, coh_pkg::CTRL_OFS, 32'h3);
		n = starts;
		coh_line_ctrl_inst.pulse(1);
		chk("starts", n, starts);
		bus(1'b1, coh_pkg::CTRL_OFS, 32'h9);
		coh_line_ctrl_inst.pulse(1);
		chk("starts", n + 1, starts);
		chkb("meas end", 1'b0, mend);
		done_pulse(3'h1);
		coh_line_ctrl_inst.await_end(ok);
		if (!ok) begin
			stop_hang();
		end
		chkb("meas end", 1'b1, mend);
		chkr(3'h1);
		n = prints;
		coh_line_ctrl_inst.print_after_end(ok);
		chk("prints", n + 1, prints);
		@(posedge clk);
		afault <= 1'b1;
		cyc(3);
		chkb("fault", 1'b1, fault);
		chkr(3'h0);
		@(posedge clk);
		afault <= 1'b0;
		cyc(3);
		bus(1'b1, coh_pkg::CTRL_OFS, 32'h5);
		done_pulse(3'h4);
		chkr(coh_pkg::RES_RV_FAIL);
		bus(1'b1, coh_pkg::CTRL_OFS, 32'h4);
		cyc(2);
		chkr(3'h0);
		$display("test trigger done");
	endtask
	task automatic t_irq;
		bus(1'b0, coh_pkg::INT_STATUS_OFS, 32'h0);
		chk("int status", 32'h7, rd);
		chkb("irq", 1'b0, irq);
		bus(1'b1, coh_pkg::INT_ENABLE_OFS, 32'h7);
		@(posedge clk);
		chkb("irq", 1'b1, irq);
		bus(1'b1, coh_pkg::INT_CLEAR_OFS, 32'h7);
		@(posedge clk);
		chkb("irq", 1'b0, irq);
		bus(1'b0, coh_pkg::INT_STATUS_OFS, 32'h0);
		chk("int status", 32'h0, rd);
		bus(1'b1, coh_pkg::INT_ENABLE_OFS, 32'h2);
		set_contact(1'b0);
		chkb("irq", 1'b1, irq);
		set_contact(1'b1);
		$display("test irq done");
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// One-cycle pulses are only visible on the edge that follows them
	always @(posedge clk) begin
		if (mstart === 1'b1) begin
			starts++;
		end
		if (pgo === 1'b1) begin
			prints++;
		end
	end
	initial begin
		rst = 1'b1;
		hsel = 1'b1;
		hsize = coh_pkg::HSIZE_WORD;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		contact = 1'b1;
		afault = 1'b0;
		mbegin = 1'b0;
		mdone = 1'b0;
		mres = 3'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fault();
		t_request();
		t_trigger();
		t_irq();
		give_verdict();
	end
endmodule
`default_nettype wire
